/* File: lsync_pkg.sv */
package lsync_pkg;
   // Register indices; byte address is index times four
   localparam logic [7:0]  IDX_DIV_HI      = 8'h01;
   localparam logic [7:0]  IDX_DIV_LO      = 8'h02;
   localparam logic [7:0]  IDX_VCO_PUMP    = 8'h03;
   localparam logic [7:0]  IDX_PHASE       = 8'h04;
   localparam logic [7:0]  IDX_SYNC_WIDTH  = 8'h07;
   localparam logic [7:0]  IDX_SYNC_CTRL   = 8'h10;
   localparam logic [7:0]  IDX_COAST_CTRL  = 8'h11;
   localparam logic [7:0]  IDX_STATUS      = 8'h20;
   // Field positions
   localparam int VCO_BAND_LSB      = 6;
   localparam int PUMP_LSB          = 3;
   localparam int PHASE_LSB         = 3;
   localparam int IN_POL_BIT        = 6;
   localparam int OUT_POL_BIT       = 5;
   localparam int AUTO_POL_BIT      = 7;
   localparam int COAST_LSB         = 1;
   // Reset values
   localparam logic [11:0] DIV_RST       = 12'h0_35F;
   localparam logic [1:0]  VCO_BAND_RST  = 2'h1;
   localparam logic [2:0]  PUMP_RST      = 3'h5;
   localparam logic [4:0]  PHASE_RST     = 5'h1_0;
   localparam logic [7:0]  WIDTH_RST     = 8'h2_0;
   localparam logic [7:0]  SYNC_CTRL_RST = 8'h8_0;
   localparam logic [2:0]  COAST_RST     = 3'h0;
   localparam logic [11:0] DIV_MIN       = 12'h0_DD;
   localparam int          PHASE_STEPS   = 32;
   // Pump current table in microamperes
   localparam logic [10:0] PUMP_UA [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA,
                                           11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};
   // Band edges in MHz
   localparam logic [7:0]  BAND_LO [3] = '{8'h0C, 8'h29, 8'h52};
   localparam logic [7:0]  BAND_HI [3] = '{8'h29, 8'h52, 8'h8C};
   // Coast control codes
   localparam logic [2:0]  COAST_OFF     = 3'h0;
   localparam logic [2:0]  COAST_LOSS    = 3'h1;
   localparam logic [2:0]  COAST_EXT     = 3'h2;
   localparam logic [2:0]  COAST_BOTH    = 3'h3;
   // Sync supervision: missing when no edge within line limit
   localparam logic [11:0] LINE_MARGIN   = 12'h0_10;
   typedef enum logic [1:0] {
      PLL_WAIT  = 2'b00,
      PLL_TRACK = 2'b01,
      PLL_COAST = 2'b11
   } pll_state_t;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage : lsync_pkg

/* File: lsync_phase_ram.sv */
`timescale 1ns/10ps
// Delay line of sync samples; read data registered
module lsync_phase_ram #(
   parameter int DEPTH = 32
) (
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] i_rd_tap,
   output logic                          o_rd_data
);
   logic [DEPTH-1:0] line_r;
   always_ff @(posedge i_ref_clk) begin
      line_r    <= {line_r[DEPTH-2:0], i_wr_data};
      o_rd_data <= line_r[i_rd_tap];
   end
endmodule : lsync_phase_ram

/* File: line_sync_pixel_clock_control.sv */
`timescale 1ns/10ps
module line_sync_pixel_clock_control
#(
   parameter int PIX_DIV = 2
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire logic        i_line_sync,
   input  wire logic        i_ext_coast,
   input  wire logic [7:0]  i_pixel_data,
   output logic             o_line_sync_out,
   output logic             o_pixel_data_clock_out,
   output logic [7:0]       o_pixel_data,
   output logic             o_vco_band_sel_hi,
   output logic             o_vco_band_sel_lo,
   output logic             o_pump_current_sel_b2,
   output logic             o_pump_current_sel_b1,
   output logic             o_pump_current_sel_b0,
   output logic [10:0]      o_pump_current_ua,
   output logic             o_coast,
   output logic             o_pll_ref_pulse,
   output logic             o_pll_fb_pulse,
   output logic             o_band_mismatch
);
   import lsync_pkg::*;

   typedef struct packed {
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] rdata;
      logic [11:0] div;
      logic [1:0]  band;
      logic [2:0]  pump;
      logic [10:0] pump_ua;
      logic [4:0]  phase;
      logic [7:0]  width;
      logic [7:0]  sync_ctrl;
      logic [2:0]  coast_ctrl;
      pll_state_t  st;
      logic        sync_d;
      logic        pol_det;
      logic [11:0] hi_cnt;
      logic [11:0] lo_cnt;
      logic [11:0] fb_cnt;
      logic [11:0] gap_cnt;
      logic        missing;
      logic        coast;
      logic        ref_pulse;
      logic        fb_pulse;
      logic [7:0]  pclk_div;
      logic        dclk;
      logic [7:0]  pix;
      logic [7:0]  out_cnt;
      logic        out_act;
      logic        out_arm;
      logic        sync_out;
      logic        mismatch;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic   sync_delayed;
   logic   sync_in;
   logic   edge_in;
   logic   pix_tick;
   logic   pix_clk;
   logic   coast_req;

   function automatic logic [7:0] reg_addr(input logic [7:0] idx);
      reg_addr = {idx[5:0], 2'b00};
   endfunction : reg_addr

   function automatic logic [1:0] band_for_mhz(input logic [7:0] mhz);
      if (mhz < BAND_HI[0]) begin
         band_for_mhz = 2'b00;
      end else if (mhz < BAND_HI[1]) begin
         band_for_mhz = 2'b01;
      end else begin
         band_for_mhz = 2'b10;
      end
   endfunction : band_for_mhz

   lsync_phase_ram #(
      .DEPTH(PHASE_STEPS)
   ) u_phase (
      .i_ref_clk (i_ref_clk),
      .i_wr_data (i_line_sync),
      .i_rd_tap  (s_r.phase),
      .o_rd_data (sync_delayed)
   );

   always_comb begin
      s_nxt = s_r;
      sync_in   = sync_delayed ^ (s_r.sync_ctrl[AUTO_POL_BIT] ? s_r.pol_det
                                  : ~s_r.sync_ctrl[IN_POL_BIT]);
      edge_in   = sync_in & ~s_r.sync_d;
      pix_tick  = (s_r.pclk_div == 8'(PIX_DIV - 1));
      pix_clk   = pix_tick & s_r.dclk;
      coast_req = 1'b0;
      // Bus write data phase
      if (s_r.wr_pend) begin
         s_nxt.wr_pend = 1'b0;
         case (s_r.wr_addr)
            reg_addr(IDX_DIV_HI): s_nxt.div[11:4] = hwdata[7:0];
            reg_addr(IDX_DIV_LO): s_nxt.div[3:0]  = hwdata[7:4];
            reg_addr(IDX_VCO_PUMP): begin
               s_nxt.band = hwdata[VCO_BAND_LSB +: 2];
               s_nxt.pump = hwdata[PUMP_LSB +: 3];
            end
            reg_addr(IDX_PHASE):      s_nxt.phase      = hwdata[PHASE_LSB +: 5];
            reg_addr(IDX_SYNC_WIDTH): s_nxt.width      = hwdata[7:0];
            reg_addr(IDX_SYNC_CTRL):  s_nxt.sync_ctrl  = hwdata[7:0];
            reg_addr(IDX_COAST_CTRL): s_nxt.coast_ctrl = hwdata[COAST_LSB +: 3];
            default: ;
         endcase
      end
      // Bus address phase
      if (hsel && hready && htrans == HTRANS_NONSEQ) begin
         s_nxt.wr_pend = hwrite;
         s_nxt.wr_addr = haddr[7:0];
         case (haddr[7:0])
            reg_addr(IDX_DIV_HI):     s_nxt.rdata = {24'h00_0000, s_r.div[11:4]};
            reg_addr(IDX_DIV_LO):     s_nxt.rdata = {24'h00_0000, s_r.div[3:0], 4'h0};
            reg_addr(IDX_VCO_PUMP):   s_nxt.rdata = {24'h00_0000, s_r.band, s_r.pump, 3'h0};
            reg_addr(IDX_PHASE):      s_nxt.rdata = {24'h00_0000, s_r.phase, 3'h0};
            reg_addr(IDX_SYNC_WIDTH): s_nxt.rdata = {24'h00_0000, s_r.width};
            reg_addr(IDX_SYNC_CTRL):  s_nxt.rdata = {24'h00_0000, s_r.sync_ctrl};
            reg_addr(IDX_COAST_CTRL): s_nxt.rdata = {28'h000_0000, s_r.coast_ctrl, 1'b0};
            reg_addr(IDX_STATUS):     s_nxt.rdata = {28'h000_0000, s_r.mismatch,
                                                     s_r.pol_det, s_r.missing, s_r.coast};
            default:                  s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      s_nxt.sync_d = sync_in;
      if (sync_delayed) begin
         s_nxt.hi_cnt = (s_r.hi_cnt == 12'hFFF) ? s_r.hi_cnt : s_r.hi_cnt + 12'h001;
      end else begin
         s_nxt.lo_cnt = (s_r.lo_cnt == 12'hFFF) ? s_r.lo_cnt : s_r.lo_cnt + 12'h001;
      end
      if (edge_in) begin
         s_nxt.pol_det = (s_r.hi_cnt > s_r.lo_cnt);
         s_nxt.hi_cnt  = 12'h000;
         s_nxt.lo_cnt  = 12'h000;
      end
      if (edge_in) begin
         s_nxt.gap_cnt = 12'h000;
         s_nxt.missing = 1'b0;
      end else if (pix_clk && s_r.gap_cnt != 12'hFFF) begin
         s_nxt.gap_cnt = s_r.gap_cnt + 12'h001;
         if (13'(s_r.gap_cnt) >= 13'(s_r.div) + 13'(LINE_MARGIN)) begin
            s_nxt.missing = 1'b1;
         end
      end
      case (s_r.coast_ctrl)
         COAST_LOSS: coast_req = s_r.missing;
         COAST_EXT:  coast_req = i_ext_coast;
         COAST_BOTH: coast_req = s_r.missing | i_ext_coast;
         default:    coast_req = 1'b0;
      endcase
      s_nxt.coast     = coast_req;
      s_nxt.ref_pulse = 1'b0;
      s_nxt.fb_pulse  = 1'b0;
      if (pix_clk) begin
         if (s_r.fb_cnt >= s_r.div) begin
            s_nxt.fb_cnt   = 12'h000;
            s_nxt.fb_pulse = 1'b1;
         end else begin
            s_nxt.fb_cnt = s_r.fb_cnt + 12'h001;
         end
      end
      case (s_r.st)
         PLL_WAIT: begin
            if (edge_in && !coast_req) begin
               s_nxt.ref_pulse = 1'b1;
               s_nxt.st        = PLL_TRACK;
            end
         end
         PLL_TRACK: begin
            if (coast_req) begin
               s_nxt.st = PLL_COAST;
            end else begin
               s_nxt.ref_pulse = edge_in;
            end
         end
         PLL_COAST: begin
            if (!coast_req) begin
               s_nxt.st = PLL_WAIT;
            end
         end
         default: s_nxt.st = PLL_WAIT;
      endcase
      // data changes on falling edge of data clock
      s_nxt.pclk_div = pix_tick ? 8'h00 : s_r.pclk_div + 8'h01;
      if (pix_tick) begin
         s_nxt.dclk = ~s_r.dclk;
         if (s_r.dclk) begin
            s_nxt.pix = i_pixel_data;
            if (edge_in || s_r.out_arm) begin
               s_nxt.out_arm = 1'b0;
               s_nxt.out_act = (s_r.width != 8'h00);
               s_nxt.out_cnt = s_r.width;
            end else if (s_r.out_cnt > 8'h01) begin
               s_nxt.out_cnt = s_r.out_cnt - 8'h01;
            end else begin
               s_nxt.out_cnt = 8'h00;
               s_nxt.out_act = 1'b0;
            end
            s_nxt.sync_out = s_nxt.out_act ^ ~s_r.sync_ctrl[OUT_POL_BIT];
         end
      end
      // Edge held until next data clock fall
      if (edge_in && !pix_clk) begin
         s_nxt.out_arm = 1'b1;
      end
      s_nxt.mismatch = (s_r.band == 2'b11) || (s_r.div < DIV_MIN);
      if (i_rst) begin
         s_nxt            = '0;
         s_nxt.div        = DIV_RST;
         s_nxt.band       = VCO_BAND_RST;
         s_nxt.pump       = PUMP_RST;
         s_nxt.phase      = PHASE_RST;
         s_nxt.width      = WIDTH_RST;
         s_nxt.sync_ctrl  = SYNC_CTRL_RST;
         s_nxt.coast_ctrl = COAST_RST;
         s_nxt.st         = PLL_WAIT;
         s_nxt.sync_out   = ~SYNC_CTRL_RST[OUT_POL_BIT];
      end
      s_nxt.pump_ua = PUMP_UA[s_nxt.pump];
   end

   always_ff @(posedge i_ref_clk) begin
      s_r <= s_nxt;
   end

   always_comb begin
      o_hrdata               = s_r.rdata;
      o_hreadyout            = 1'b1;
      o_hresp                = 1'b0;
      o_line_sync_out        = s_r.sync_out;
      o_pixel_data_clock_out = s_r.dclk;
      o_pixel_data           = s_r.pix;
      o_vco_band_sel_hi      = s_r.band[1];
      o_vco_band_sel_lo      = s_r.band[0];
      o_pump_current_sel_b2  = s_r.pump[2];
      o_pump_current_sel_b1  = s_r.pump[1];
      o_pump_current_sel_b0  = s_r.pump[0];
      o_pump_current_ua      = s_r.pump_ua;
      o_coast                = s_r.coast;
      o_pll_ref_pulse        = s_r.ref_pulse;
      o_pll_fb_pulse         = s_r.fb_pulse;
      o_band_mismatch        = s_r.mismatch;
   end

   property p_coast_gate;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_r.coast |-> !s_r.ref_pulse;
   endproperty
   a_coast_gate: assert property (p_coast_gate) else $error("reference passed in coast");

   // divider not reset by coast end
   property p_resume_keep;
      @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.st == PLL_COAST && s_nxt.st == PLL_WAIT && s_r.fb_cnt < s_r.div && pix_clk)
      |=> s_r.fb_cnt == $past(s_r.fb_cnt) + 12'h001;
   endproperty
   a_resume_keep: assert property (p_resume_keep) else $error("divider reset on resume");

   property p_div_wrap;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_r.fb_pulse |-> s_r.fb_cnt == 12'h000;
   endproperty
   a_div_wrap: assert property (p_div_wrap) else $error("divider pulse off wrap");

   property p_pump_top;
      @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.pump == 3'h7) |-> o_pump_current_ua == 11'h5DC;
   endproperty
   a_pump_top: assert property (p_pump_top) else $error("pump top current wrong");

   // sync out changes only with data clock edge
   property p_sync_align;
      @(posedge i_ref_clk) disable iff (i_rst)
      $changed(o_line_sync_out) |-> $fell(o_pixel_data_clock_out);
   endproperty
   a_sync_align: assert property (p_sync_align) else $error("sync out misaligned");

   // data stable at rising clock edge
   property p_data_mid;
      @(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_pixel_data_clock_out) |-> $stable(o_pixel_data);
   endproperty
   a_data_mid: assert property (p_data_mid) else $error("data moved on rising clock");

   property p_coast_loss;
      @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.coast_ctrl == COAST_LOSS && s_r.missing) |=> s_r.coast;
   endproperty
   a_coast_loss: assert property (p_coast_loss) else $error("no coast on loss");

   property p_band_wr;
      @(posedge i_ref_clk) disable iff (i_rst)
      (s_r.wr_pend && s_r.wr_addr == reg_addr(IDX_VCO_PUMP))
      |=> o_vco_band_sel_hi == $past(hwdata[7]) && o_pump_current_sel_b0 == $past(hwdata[3]);
   endproperty
   a_band_wr: assert property (p_band_wr) else $error("band pump write lost");
endmodule : line_sync_pixel_clock_control

/* File: lsync_source.sv */
`timescale 1ns/10ps
// Video source: line sync pulses and ever-changing pixel data
module lsync_source (
   input  wire logic        i_ref_clk,
   input  wire logic        i_run,
   input  wire logic        i_pol_high,
   input  wire logic [15:0] i_period,
   output logic             o_line_sync,
   output logic [7:0]       o_pixel_data
);
   logic [15:0] cnt_r  = 16'h0000;
   logic        sync_r = 1'b1;
   logic [7:0]  pix_r  = 8'h00;
   assign o_line_sync  = sync_r;
   assign o_pixel_data = pix_r;
   always @(posedge i_ref_clk) begin
      cnt_r <= (cnt_r + 16'h0001 >= i_period) ? 16'h0000 : cnt_r + 16'h0001;
      sync_r <= (i_run && cnt_r < 16'h0028) ? i_pol_high : ~i_pol_high;
      pix_r  <= pix_r + 8'h3B;
   end
endmodule : lsync_source

/* File: line_sync_pixel_clock_control_test.sv */
`timescale 1ns/10ps
module line_sync_pixel_clock_control_test;
   import lsync_pkg::*;
   localparam int PD = 2;
   localparam int P  = 222 * 2 * PD;
   logic        i_ref_clk, i_rst, hsel, hwrite, hrdy, ext, run, spol, opol, align_on;
   logic [31:0] haddr, hwdata, o_hrdata, e, g, v;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  pix_in, o_pixel_data, lf;
   logic        o_line_sync_out, dck, sync_in, o_coast, ref_p, fb_p, mism;
   logic        bhi, blo, p2, p1, p0, in_prev, o_prev, dck_prev, sync_prev;
   logic [7:0]  pd_prev;
   logic [10:0] ua;
   logic [31:0] exp_q[$], got_q[$];
   int          errors, checked, cyc, t_in, t_out, t_fb, lat, wlast, fb_int, ref_n, r0, l0;
   int          ua_tbl[8] = '{50, 100, 150, 250, 350, 500, 750, 1500};
   logic        resp;
   logic [7:0]  ri[6] = '{8'h04, 8'h07, 8'h10, 8'h01, 8'h02, 8'h3F};
   logic [31:0] rv[6] = '{32'h80, 32'h20, 32'h80, 32'h35, 32'hF0, 32'h00};
   line_sync_pixel_clock_control #(.PIX_DIV(PD)) dut_u (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .o_hrdata(o_hrdata),
      .o_hreadyout(hrdy), .o_hresp(resp), .i_line_sync(sync_in), .i_ext_coast(ext),
      .i_pixel_data(pix_in), .o_line_sync_out(o_line_sync_out),
      .o_pixel_data_clock_out(dck), .o_pixel_data(o_pixel_data), .o_vco_band_sel_hi(bhi),
      .o_vco_band_sel_lo(blo), .o_pump_current_sel_b2(p2), .o_pump_current_sel_b1(p1),
      .o_pump_current_sel_b0(p0), .o_pump_current_ua(ua), .o_coast(o_coast),
      .o_pll_ref_pulse(ref_p), .o_pll_fb_pulse(fb_p), .o_band_mismatch(mism));
   lsync_source src_u (.i_ref_clk(i_ref_clk), .i_run(run), .i_pol_high(spol),
      .i_period(16'(P)), .o_line_sync(sync_in), .o_pixel_data(pix_in));
   initial begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic put(input logic [31:0] ex, input logic [31:0] gt);
      exp_q.push_back(ex);
      got_q.push_back(gt);
   endtask : put
   task automatic results;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   task automatic hold;
      int n;
      n = 0;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (hrdy !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         results();
      end
   endtask : hold
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {22'h00_0000, idx, 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= HSIZE_WORD;
      hold();
      htrans <= 2'h0;
      hwdata <= wd;
      hold();
      rd = o_hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus(idx, 1'b1, d, v);
      repeat (3) @(posedge i_ref_clk);
   endtask : wr
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] ex);
      bus(idx, 1'b0, 32'h0000_0000, v);
      put(ex, v);
      put(32'h0, {31'h0, resp});
   endtask : rdchk
   task automatic lines(input int n);
      repeat (n * P) @(posedge i_ref_clk);
   endtask : lines
   always @(negedge i_ref_clk) begin
      while (got_q.size() > 0) begin
         e = exp_q.pop_front();
         g = got_q.pop_front();
         checked++;
         if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   end
   always @(posedge i_ref_clk) begin
      cyc++;
      if ((sync_in === spol) && !in_prev) t_in = cyc;
      if ((o_line_sync_out === opol) && !o_prev) begin
         t_out = cyc;
         lat   = cyc - t_in;
      end
      if ((o_line_sync_out !== opol) && o_prev) wlast = cyc - t_out;
      if (fb_p === 1'b1) begin
         fb_int = cyc - t_fb;
         t_fb   = cyc;
      end
      if (ref_p === 1'b1) ref_n++;
      if (align_on && (o_line_sync_out !== sync_prev || o_pixel_data !== pd_prev))
         put(32'h1, {31'h0, dck_prev === 1'b1 && dck === 1'b0});
      in_prev   = (sync_in === spol);
      o_prev    = (o_line_sync_out === opol);
      dck_prev  = dck;
      sync_prev = o_line_sync_out;
      pd_prev   = o_pixel_data;
   end
   initial begin
      repeat (100000) @(posedge i_ref_clk);
      errors++;
      results();
   end
   initial begin
      {hsel, hwrite, ext, run, opol, align_on} = '0;
      {haddr, hwdata, htrans, hsize} = '0;
      {cyc, ref_n, t_in, t_out, t_fb, lat, wlast, fb_int} = '0;
      i_rst = 1'b1;
      spol  = 1'b1;
      lf    = 8'd28;
      repeat (8) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      rdchk(8'h03, 32'h68);
      for (int i = 0; i < 6; i++) rdchk(ri[i], rv[i]);
      put(32'd500, {21'h0, ua});
      $display("test reset done");
      wr(8'h01, 32'h0D);
      wr(8'h02, 32'hD0);
      for (int b = 0; b < 4; b++) begin
         for (int p = 0; p < 8; p++) begin
            wr(8'h03, {24'h0, b[1:0], p[2:0], 3'b000});
            put({27'h0, b[1:0], p[2:0]}, {27'h0, bhi, blo, p2, p1, p0});
            put(ua_tbl[p], {21'h0, ua});
            put({31'h0, b == 3}, {31'h0, mism});
         end
      end
      wr(8'h03, 32'h68);
      wr(8'h02, 32'hC0);
      put(32'h1, {31'h0, mism});
      wr(8'h02, 32'hD0);
      put(32'h0, {31'h0, mism});
      $display("test codes done");
      repeat (4) begin
         lf = lfsr(lf);
         wr(8'h07, {4{lf}});
         rdchk(8'h07, {24'h0, lf});
      end
      wr(8'h07, 32'h05);
      wr(8'h10, 32'hA0);
      opol = 1'b1;
      run <= 1'b1;
      lines(3);
      align_on = 1'b1;
      lines(2);
      put(5 * 2 * PD, wlast);
      rdchk(8'h20, 32'h00);
      r0 = ref_n;
      lines(4);
      put(32'd4, ref_n - r0);
      put(P, fb_int);
      align_on = 1'b0;
      $display("test sync out done");
      spol <= 1'b0;
      lines(3);
      rdchk(8'h20, 32'h04);
      wr(8'h10, 32'h00);
      opol = 1'b0;
      lines(3);
      put(5 * 2 * PD, wlast);
      wr(8'h04, 32'h00);
      lines(3);
      l0 = lat;
      wr(8'h04, 32'h80);
      lines(3);
      put(32'd16, lat - l0);
      $display("test polarity phase done");
      ext <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         wr(8'h11, {28'h0, m[2:0], 1'b0});
         put({31'h0, m[1]}, {31'h0, o_coast});
         r0 = ref_n;
         lines(2);
         put(m[1] ? 32'd0 : 32'd2, ref_n - r0);
         put(P, fb_int);
      end
      ext <= 1'b0;
      wr(8'h11, 32'h02);
      run <= 1'b0;
      lines(3);
      put(32'h1, {31'h0, o_coast});
      r0 = ref_n;
      lines(1);
      put(32'd0, ref_n - r0);
      put(P, fb_int);
      run <= 1'b1;
      lines(3);
      put(32'h0, {31'h0, o_coast});
      r0 = ref_n;
      lines(2);
      put(32'd2, ref_n - r0);
      wr(8'h11, 32'h00);
      run <= 1'b0;
      lines(3);
      put(32'h0, {31'h0, o_coast});
      $display("test coast done");
      repeat (2) @(negedge i_ref_clk);
      results();
   end
endmodule : line_sync_pixel_clock_control_test
